/* File: logic/msg_framer_defs.svh */
// Constants for the binary message header framer.
`ifndef MSG_FRAMER_DEFS_SVH
`define MSG_FRAMER_DEFS_SVH
`define MF_START0        8'hC1
`define MF_START1        8'hC0
`define MF_FOOTER        32'hC5C4C3C2
`define MF_PROTO_VER     16'h1000
`define MF_HDR_LEN       6'd44
`define MF_OFS_FLAGS     6'd4
`define MF_OFS_ERR       6'd6
`define MF_OFS_TYPE      6'd8
`define MF_OFS_TAG       6'd12
`define MF_OFS_RSVD      6'd16
`define MF_OFS_CKTYPE    6'd22
`define MF_OFS_IMMLEN    6'd23
`define MF_OFS_IMM       6'd24
`define MF_OFS_REMAIN    6'd40
`define MF_CK_LEN        32'd16
`define MF_TRAILER_LEN   32'd20
`define MF_IMM_MAX       8'h10
`define MF_ERR_LAYOUT    16'd101
`define MF_ERR_PKTSIZE   16'd102
`define MF_ERR_HWREV     16'd103
`define MF_ERR_FLASHMAP  16'd104
`define MF_ERR_DEFERRED  16'd255
`define MF_FLAG_NACK     2
`define MF_FLAG_EXC      4
`define MF_REG_CTRL      12'h000
`define MF_REG_TYPE      12'h004
`define MF_REG_TAG       12'h008
`define MF_REG_IMM0      12'h00C
`define MF_REG_IMM1      12'h010
`define MF_REG_IMM2      12'h014
`define MF_REG_IMM3      12'h018
`define MF_REG_STATUS    12'h01C
`define MF_REG_RTYPE     12'h020
`define MF_REG_RTAG      12'h024
`define MF_REG_RERR      12'h028
`define MF_REG_RREMAIN   12'h02C
`define MF_REG_RIMM0     12'h030
`define MF_REG_PLEN      12'h034
`endif

/* File: logic/msg_framer_pkg.sv */
// Types shared by the message framer files.
package msg_framer_pkg;
   typedef struct packed {
      logic [31:0] cmd_type;
      logic [31:0] tag;
      logic [7:0]  imm_len;
      logic [127:0] imm;
   } req_hdr_s;
   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] err;
      logic [31:0] cmd_type;
      logic [31:0] tag;
      logic [7:0]  ck_type;
      logic [7:0]  imm_len;
      logic [127:0] imm;
      logic [31:0] remain;
   } rsp_hdr_s;
   typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_TRAIL} tx_state_e;
   typedef enum logic [2:0] {RX_HUNT0, RX_HUNT1, RX_HDR, RX_BODY, RX_DONE} rx_state_e;
endpackage

/* File: logic/msg_byte_sync.sv */
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module msg_byte_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   initial begin
      if (WIDTH < 1) $error("WIDTH must be at least one");
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule

/* File: logic/msg_host_framer.sv */
// Host-side framer: builds requests and parses responses of the binary message protocol.
//
// Functional notes
// - Header order: marker, version, flags, error, type, tag, reserved, cktype, imm.
// - Every message starts with bytes C1 then C0; otherwise unframed.
// - Command type is the 32-bit field at byte offset 8.
// - Checksum type zero means no checksum; 16-byte block still sent.
// - Checksum type one means full MD5 digest, verified by receiver; this framer only flags a nonzero type in status.
// - Immediate length at offset 23 counts valid immediate bytes, zero to sixteen.
// - Operands in immediate area at offset 24 mean no payload appended.
// - Remaining length at offset 40 counts payload, checksum block and footer.
// - Payload length equals remaining length minus checksum and footer length.
// - Code 255 means deferred; neither acknowledgement nor negative acknowledgement.
// - Checksum block followed by footer C5C4C3C2, order not reversed.
// - Checksum covers start marker through last payload byte only.
// - Multi-byte integers travel least significant byte first.
`timescale 1ns/1ps
`include "msg_framer_defs.svh"
module msg_host_framer
   import msg_framer_pkg::*;
#(
   parameter int MAX_BODY = 64
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [7:0]       tx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_valid
);
   initial begin
      if (MAX_BODY < 20) $error("MAX_BODY must cover checksum and footer");
   end

   // Pin inputs: the serial byte stream comes from outside this clock domain.
   logic [9:0] rx_sync;
   logic [9:0] rx_pins;
   // Ready shares the synchroniser; only its rising edge takes a byte, so a slow ready
   // that stays high never takes two bytes.
   assign rx_pins = {tx_ready, rx_valid, rx_data};
   msg_byte_sync #(.WIDTH(10)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (rx_pins),
      .q       (rx_sync)
   );
   wire       rdy_s  = rx_sync[9];
   wire       rv_s   = rx_sync[8];
   wire [7:0] rb_s   = rx_sync[7:0];
   logic      rv_d_ff;
   wire       rx_stb = rv_s & ~rv_d_ff;

   // Request registers written by software.
   req_hdr_s  req_ff;
   logic      go_ff;
   wire       wr  = psel & penable & pwrite;
   wire [4:0] imm_word = 5'(paddr[4:2] - 3'd3);

   // Transmitter.
   tx_state_e tx_st_ff;
   logic [5:0] tx_idx_ff;
   logic [7:0] tx_byte;
   logic [7:0] tx_data_ff;
   logic       tx_valid_ff;
   logic       rdy_d_ff;
   wire        tx_take = tx_valid_ff & rdy_s & ~rdy_d_ff;
   wire [7:0]  imm_len_cl = (req_ff.imm_len > `MF_IMM_MAX) ? `MF_IMM_MAX : req_ff.imm_len;
   wire [3:0]  imm_b = 4'(tx_idx_ff - `MF_OFS_IMM);
   wire [127:0] imm_sh = req_ff.imm >> {imm_b, 3'b000};
   wire [1:0]  ty_b = 2'(tx_idx_ff - `MF_OFS_TYPE);
   wire [1:0]  tg_b = 2'(tx_idx_ff - `MF_OFS_TAG);
   wire [1:0]  rm_b = 2'(tx_idx_ff - `MF_OFS_REMAIN);
   wire [31:0] tx_trail = `MF_TRAILER_LEN;
   wire [31:0] ftr = `MF_FOOTER;

   always_comb begin
      tx_byte = 8'h00;
      if (tx_idx_ff == 6'd0)                 tx_byte = `MF_START0;
      else if (tx_idx_ff == 6'd1)            tx_byte = `MF_START1;
      else if (tx_idx_ff == 6'd2)            tx_byte = 8'(`MF_PROTO_VER);
      else if (tx_idx_ff == 6'd3)            tx_byte = 8'(`MF_PROTO_VER >> 8);
      else if (tx_idx_ff < `MF_OFS_TYPE)     tx_byte = 8'h00;
      else if (tx_idx_ff < `MF_OFS_TAG)      tx_byte = 8'(req_ff.cmd_type >> {ty_b, 3'b000});
      else if (tx_idx_ff < `MF_OFS_RSVD)     tx_byte = 8'(req_ff.tag >> {tg_b, 3'b000});
      else if (tx_idx_ff < `MF_OFS_CKTYPE)   tx_byte = 8'h00;
      // Type zero is always sent, so no digest has to be computed over the message.
      else if (tx_idx_ff == `MF_OFS_CKTYPE)  tx_byte = 8'h00;
      else if (tx_idx_ff == `MF_OFS_IMMLEN)  tx_byte = imm_len_cl;
      else if (tx_idx_ff < `MF_OFS_REMAIN)   tx_byte = (imm_b < imm_len_cl[4:0]) ? imm_sh[7:0] : 8'h00;
      else                                   tx_byte = 8'(tx_trail >> {rm_b, 3'b000});
   end
   // The trailer: sixteen zero bytes then footer bytes C5 C4 C3 C2.
   wire [7:0] trail_byte = (tx_idx_ff < 6'd16) ? 8'h00 :
                           8'(ftr >> {2'(2'd3 - tx_idx_ff[1:0]), 3'b000});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_ff    <= TX_IDLE;
         tx_idx_ff   <= 6'd0;
         tx_data_ff  <= 8'h00;
         tx_valid_ff <= 1'b0;
         rdy_d_ff    <= 1'b0;
      end else begin
         rdy_d_ff <= rdy_s;
         case (tx_st_ff)
            TX_IDLE: if (go_ff) begin
               tx_st_ff  <= TX_HDR;
               tx_idx_ff <= 6'd0;
            end
            TX_HDR: if (!tx_valid_ff) begin
               tx_data_ff  <= tx_byte;
               tx_valid_ff <= 1'b1;
            end else if (tx_take) begin
               tx_valid_ff <= 1'b0;
               if (tx_idx_ff == `MF_HDR_LEN - 6'd1) begin
                  tx_st_ff  <= TX_TRAIL;
                  tx_idx_ff <= 6'd0;
               end else tx_idx_ff <= tx_idx_ff + 6'd1;
            end
            TX_TRAIL: if (!tx_valid_ff) begin
               tx_data_ff  <= trail_byte;
               tx_valid_ff <= 1'b1;
            end else if (tx_take) begin
               tx_valid_ff <= 1'b0;
               if (tx_idx_ff == 6'd19) tx_st_ff <= TX_IDLE;
               else tx_idx_ff <= tx_idx_ff + 6'd1;
            end
            default: tx_st_ff <= TX_IDLE;
         endcase
      end
   end
   assign tx_data  = tx_data_ff;
   assign tx_valid = tx_valid_ff;

   // Receiver.
   rx_state_e  rx_st_ff;
   logic [5:0] rx_idx_ff;
   logic [31:0] rx_cnt_ff;
   rsp_hdr_s   rsp_ff;
   logic       rx_done_ff;
   logic       rx_unfr_ff;
   logic       rx_over_ff;
   logic [31:0] plen_ff;
   wire [4:0]  ri = 5'(rx_idx_ff - `MF_OFS_IMM);
   wire [1:0]  rb = rx_idx_ff[1:0];
   wire [31:0] rx_body_len = rsp_ff.remain;
   wire        rsp_deferred = rsp_ff.err == `MF_ERR_DEFERRED;
   wire        rsp_nack = rsp_ff.flags[`MF_FLAG_NACK] & ~rsp_deferred;
   wire        rsp_err_bad = (rsp_ff.err != 16'h0000) &
                             ~(rsp_ff.flags[`MF_FLAG_NACK] | rsp_ff.flags[`MF_FLAG_EXC]);
   wire        rsp_dev_err = (rsp_ff.err >= `MF_ERR_LAYOUT) & (rsp_ff.err <= `MF_ERR_FLASHMAP);
   wire        imm_valid = (plen_ff == 32'd0);
   // Digests are not checked here: a response with a nonzero checksum type is only
   // flagged, and software must verify it before trusting the data.
   wire        ck_unchecked = rsp_ff.ck_type != 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_ff   <= RX_HUNT0;
         rx_idx_ff  <= 6'd0;
         rx_cnt_ff  <= 32'd0;
         rsp_ff     <= '0;
         rx_unfr_ff <= 1'b0;
         rx_over_ff <= 1'b0;
         plen_ff    <= 32'd0;
         rv_d_ff    <= 1'b0;
      end else begin
         rv_d_ff <= rv_s;
         // The clear comes first so that a mismatch in the same cycle wins over it.
         if (wr && paddr == `MF_REG_STATUS && pwdata[1]) rx_unfr_ff <= 1'b0;
         if (rx_stb) begin
            case (rx_st_ff)
               RX_HUNT0: if (rb_s == `MF_START0) rx_st_ff <= RX_HUNT1;
                         else rx_unfr_ff <= 1'b1;
               RX_HUNT1: if (rb_s == `MF_START1) begin
                  rx_st_ff  <= RX_HDR;
                  rx_idx_ff <= 6'd2;
               end else if (rb_s != `MF_START0) begin
                  rx_st_ff   <= RX_HUNT0;
                  rx_unfr_ff <= 1'b1;
               end
               RX_HDR: begin
                  rx_idx_ff <= rx_idx_ff + 6'd1;
                  if (rx_idx_ff >= `MF_OFS_FLAGS && rx_idx_ff < `MF_OFS_ERR)
                     rsp_ff.flags[{rb[0], 3'b000} +: 8] <= rb_s;
                  else if (rx_idx_ff >= `MF_OFS_ERR && rx_idx_ff < `MF_OFS_TYPE)
                     rsp_ff.err[{rb[0], 3'b000} +: 8] <= rb_s;
                  else if (rx_idx_ff >= `MF_OFS_TYPE && rx_idx_ff < `MF_OFS_TAG)
                     rsp_ff.cmd_type[{rb, 3'b000} +: 8] <= rb_s;
                  else if (rx_idx_ff >= `MF_OFS_TAG && rx_idx_ff < `MF_OFS_RSVD)
                     rsp_ff.tag[{rb, 3'b000} +: 8] <= rb_s;
                  else if (rx_idx_ff == `MF_OFS_CKTYPE) rsp_ff.ck_type <= rb_s;
                  else if (rx_idx_ff == `MF_OFS_IMMLEN) rsp_ff.imm_len <= rb_s;
                  else if (rx_idx_ff >= `MF_OFS_IMM && rx_idx_ff < `MF_OFS_REMAIN)
                     rsp_ff.imm[{ri[3:0], 3'b000} +: 8] <= rb_s;
                  else if (rx_idx_ff >= `MF_OFS_REMAIN)
                     rsp_ff.remain[{rb, 3'b000} +: 8] <= rb_s;
                  if (rx_idx_ff == `MF_HDR_LEN - 6'd1) begin
                     rx_st_ff  <= RX_BODY;
                     rx_cnt_ff <= 32'd0;
                  end
               end
               RX_BODY: begin
                  rx_cnt_ff <= rx_cnt_ff + 32'd1;
                  if (rx_cnt_ff + 32'd1 >= rx_body_len) rx_st_ff <= RX_DONE;
               end
               default: rx_st_ff <= rx_st_ff;
            endcase
         end
         // A length below the trailer size is malformed; the frame is closed at once
         // rather than waiting for bytes that never come.
         if (rx_st_ff == RX_BODY && rx_body_len < `MF_TRAILER_LEN) rx_st_ff <= RX_DONE;
         if (rx_st_ff == RX_BODY && rx_cnt_ff == 32'd0) begin
            // The body is still read to its end so that the stream stays in step.
            rx_over_ff <= rx_body_len > 32'(MAX_BODY);
            plen_ff <= (rx_body_len > `MF_TRAILER_LEN) ? rx_body_len - `MF_TRAILER_LEN : 32'd0;
         end
         if (rx_st_ff == RX_DONE) rx_st_ff <= RX_HUNT0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rx_done_ff <= 1'b0;
      else if (rx_st_ff == RX_DONE) rx_done_ff <= 1'b1;
      else if (wr && paddr == `MF_REG_STATUS && pwdata[0]) rx_done_ff <= 1'b0;
   end

   // APB slave, zero wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_ff  <= '0;
         go_ff   <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         // A start while a request is still going out is dropped, not queued.
         go_ff <= wr && paddr == `MF_REG_CTRL && pwdata[0] && tx_st_ff == TX_IDLE;
         if (wr) begin
            if (paddr == `MF_REG_TYPE) req_ff.cmd_type <= pwdata;
            if (paddr == `MF_REG_TAG)  req_ff.tag <= pwdata;
            if (paddr == `MF_REG_CTRL) req_ff.imm_len <= pwdata[15:8];
            if (paddr >= `MF_REG_IMM0 && paddr <= `MF_REG_IMM3)
               req_ff.imm[{imm_word[1:0], 5'b00000} +: 32] <= pwdata;
         end
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `MF_REG_CTRL:    prdata <= {16'h0000, req_ff.imm_len, 7'h00, tx_st_ff != TX_IDLE};
               `MF_REG_TYPE:    prdata <= req_ff.cmd_type;
               `MF_REG_TAG:     prdata <= req_ff.tag;
               `MF_REG_STATUS:  prdata <= {23'h000000, ck_unchecked, imm_valid, rsp_dev_err,
                                           rsp_err_bad,
                                           rsp_deferred, rsp_nack, rx_over_ff, rx_unfr_ff,
                                           rx_done_ff};
               `MF_REG_RTYPE:   prdata <= rsp_ff.cmd_type;
               `MF_REG_RTAG:    prdata <= rsp_ff.tag;
               `MF_REG_RERR:    prdata <= {rsp_ff.flags, rsp_ff.err};
               `MF_REG_RREMAIN: prdata <= rsp_ff.remain;
               `MF_REG_RIMM0:   prdata <= imm_valid ? rsp_ff.imm[31:0] : 32'h0000_0000;
               `MF_REG_PLEN:    prdata <= plen_ff;
               default:         prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   a_tx_marker: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_st_ff == TX_HDR && tx_idx_ff == 6'd0 && tx_valid_ff) |-> tx_data_ff == `MF_START0)
      else $error("first request byte is not the start marker");
   a_tx_footer: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_st_ff == TX_TRAIL && tx_idx_ff == 6'd16 && tx_valid_ff) |-> tx_data_ff == 8'hC5)
      else $error("footer first byte wrong");
   a_tx_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_valid_ff && !tx_take) |=> tx_valid_ff && $stable(tx_data_ff))
      else $error("transmit byte changed before it was taken");
   a_rx_plen: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_st_ff == RX_DONE && rx_body_len >= `MF_TRAILER_LEN)
      |-> plen_ff == rx_body_len - `MF_TRAILER_LEN)
      else $error("payload length mismatch");
   a_tx_remain: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_st_ff == TX_HDR && tx_idx_ff == `MF_OFS_REMAIN && tx_valid_ff)
      |-> tx_data_ff == 8'(`MF_TRAILER_LEN))
      else $error("remaining length low byte wrong");
   a_rx_done_set: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_st_ff == RX_DONE) |=> rx_done_ff)
      else $error("done flag not set after a complete response");
   a_rx_resync: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_stb && rx_st_ff == RX_HUNT1 && rb_s != `MF_START1 && rb_s != `MF_START0)
      |=> rx_st_ff == RX_HUNT0 && rx_unfr_ff)
      else $error("marker mismatch not flagged or hunt not restarted");
endmodule

/* File: test/msg_device_model.sv */
// Behavioural device that answers each framed request with a response set by the bench.
`timescale 1ns/1ps
`include "msg_framer_defs.svh"
module msg_device_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [7:0]       rx_data,
   output logic             rx_valid,
   input  wire logic [31:0] rsp_word,
   input  wire logic [31:0] rsp_remain,
   input  wire logic        rsp_junk
);
   logic [7:0]  req [0:127];
   logic [7:0]  r   [0:127];
   logic [31:0] rem;
   int          n;
   task automatic get_byte(output logic [7:0] b);
      while (tx_valid !== 1'b1) @(posedge pclk);
      b = tx_data;
      tx_ready <= 1'b1;
      while (tx_valid === 1'b1) @(posedge pclk);
      tx_ready <= 1'b0;
      // The low level must cross the framer's synchroniser before the next rise.
      repeat (4) @(posedge pclk);
   endtask
   task automatic put_byte(input logic [7:0] b);
      rx_data <= b;
      repeat (4) @(posedge pclk);
      rx_valid <= 1'b1;
      repeat (4) @(posedge pclk);
      rx_valid <= 1'b0;
      repeat (4) @(posedge pclk);
      // The line is not held after the strobe, so it shows a changed value.
      rx_data <= ~b;
      @(posedge pclk);
   endtask
   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      forever begin
         @(posedge pclk);
         if (presetn === 1'b1) begin
            for (int i = 0; i < 44; i++) get_byte(req[i]);
            rem = {req[43], req[42], req[41], req[40]};
            n = (rem > 32'h54) ? 128 : 44 + int'(rem);
            for (int i = 44; i < n; i++) get_byte(req[i]);
            n = 44 + int'(rsp_remain);
            r = '{default: 8'h00};
            {r[1], r[0], r[3], r[2]} = {`MF_START1, `MF_START0, `MF_PROTO_VER};
            {r[5], r[4], r[7], r[6]} = rsp_word;
            for (int i = 8; i < 16; i++) r[i] = req[i];
            for (int i = 24; i < 40; i++) r[i] = req[i];
            {r[43], r[42], r[41], r[40]} = rsp_remain;
            for (int i = 44; i < n - 20; i++) r[i] = 8'(i);
            {r[n-4], r[n-3], r[n-2], r[n-1]} = `MF_FOOTER;
            if (rsp_junk) begin
               put_byte(`MF_START0);
               put_byte(8'h3C);
            end
            for (int i = 0; i < n; i++) put_byte(r[i]);
         end
      end
   end
endmodule

/* File: test/msg_host_framer_tb.sv */
// Self-checking bench: host framer driven over APB against the behavioural device.
`timescale 1ns/1ps
`include "msg_framer_defs.svh"
module msg_host_framer_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        tx_valid, tx_ready, rx_valid, m_junk;
   logic [7:0]  tx_data, rx_data;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, st, m_word, m_remain;
   logic [7:0]  e [0:63];
   int          err_count, n_tests;
   msg_host_framer #(.MAX_BODY(64)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid));
   msg_device_model u_dev (
      .pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rsp_word(m_word),
      .rsp_remain(m_remain), .rsp_junk(m_junk));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic end_sim(input logic hung);
      if (hung) err_count++;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   // Each transfer starts just after an edge; an idle cycle follows so psel never toggles twice.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      q = prdata;
      {psel, penable} <= 2'b00;
      if (k >= 100) end_sim(1'b1);
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      chk(q, exp, msg);
   endtask
   task automatic run(input logic [31:0] typ, input logic [7:0] ilen, input logic [15:0] fl,
                      input logic [15:0] er, input logic [31:0] rem, input logic jk);
      int k;
      logic [31:0] tag;
      tag = typ ^ 32'h5A5AC3C3;
      {m_word, m_remain, m_junk} <= {fl, er, rem, jk};
      apb(1'b1, `MF_REG_TYPE, typ);
      apb(1'b1, `MF_REG_TAG, tag);
      apb(1'b1, `MF_REG_IMM0, ~tag);
      apb(1'b1, `MF_REG_CTRL, {16'h0, ilen, 8'h01});
      k = 0;
      do begin
         apb(1'b0, `MF_REG_STATUS, 32'h0);
         k++;
      end while (q[0] !== 1'b1 && k < 3000);
      if (k >= 3000) end_sim(1'b1);
      st = q;
      e = '{default: 8'h00};
      {e[1], e[0], e[3], e[2]} = {`MF_START1, `MF_START0, `MF_PROTO_VER};
      {e[11], e[10], e[9], e[8], e[15], e[14], e[13], e[12]} = {typ, tag};
      e[23] = (ilen > `MF_IMM_MAX) ? `MF_IMM_MAX : ilen;
      {e[27], e[26], e[25], e[24]} = ~tag;
      e[40] = 8'h14;
      {e[60], e[61], e[62], e[63]} = `MF_FOOTER;
      for (int i = 0; i < 64; i++) chk({24'h0, u_dev.req[i]}, {24'h0, e[i]}, "req byte");
      rd(`MF_REG_RTAG, tag, "tag");
      rd(`MF_REG_RTYPE, typ, "type");
      rd(`MF_REG_RERR, {fl, er}, "flags code");
      rd(`MF_REG_RREMAIN, rem, "remain");
      rd(`MF_REG_PLEN, rem - `MF_TRAILER_LEN, "payload len");
      rd(`MF_REG_RIMM0, (rem == 32'h14) ? ~tag : 32'h0, "imm word");
      apb(1'b1, `MF_REG_STATUS, 32'h1);
      apb(1'b0, `MF_REG_STATUS, 32'h0);
      chk({31'h0, q[0]}, 32'h0, "done clear");
   endtask
   initial begin
      #1ms;
      end_sim(1'b1);
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, m_word, m_junk, presetn} = '0;
      m_remain = 32'h14;
      err_count = 0;
      n_tests = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`MF_REG_STATUS, 32'h80, "status reset");
      apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
      rd(12'h0FC, 32'h0, "unmapped");
      run(32'h00110010, 8'h04, 16'h0, 16'h0, 32'h14, 1'b0);
      chk({23'h0, st[8:1]}, 32'h40, "clean status");
      run(32'h00101000, 8'h10, 16'h0, 16'h0, 32'h18, 1'b0);
      chk({23'h0, st[8:1]}, 32'h0, "payload status");
      run(32'h00101001, 8'h04, 16'h0, 16'h0, 32'h44, 1'b0);
      chk({31'h0, st[2]}, 32'h1, "oversize");
      run(32'h00200001, 8'h20, 16'h0010, `MF_ERR_DEFERRED, 32'h14, 1'b0);
      chk({30'h0, st[4], st[3]}, 32'h2, "deferred");
      run(32'h00300002, 8'h04, 16'h0, `MF_ERR_LAYOUT, 32'h14, 1'b0);
      chk({31'h0, st[5]}, 32'h1, "code no flag");
      for (int c = 101; c <= 104; c++) begin
         run(32'h00400000 + c, 8'h04, 16'h0004, 16'(c), 32'h14, 1'b0);
         chk({30'h0, st[6], st[3]}, 32'h3, "nack code");
      end
      run(32'hFFFFFFFF, 8'h08, 16'h0, 16'h0, 32'h14, 1'b1);
      rd(`MF_REG_STATUS, 32'h82, "unframed");
      apb(1'b1, `MF_REG_STATUS, 32'h2);
      rd(`MF_REG_STATUS, 32'h80, "unframed clear");
      end_sim(1'b0);
   end
endmodule
